// File: logic/host_access_pkg.sv
package host_access_pkg;
    localparam int unsigned REG_COUNT      = 118;
    localparam int unsigned ADDR_W         = 7;
    localparam int unsigned DATA_W         = 8;
    localparam int unsigned SYS_CLK_MHZ    = 100;
    localparam int unsigned HOLDOFF_MS     = 250;
    localparam int unsigned HOLDOFF_CYCLES = HOLDOFF_MS * 1000 * SYS_CLK_MHZ;
    localparam int unsigned EPROM_ACC_NS   = 920;
    localparam int unsigned EPROM_CYCLES   = (EPROM_ACC_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam logic [6:0]  MW_LOW_ADDR    = 7'h0c;
    localparam logic [6:0]  MW_HIGH_ADDR   = 7'h0d;
    localparam logic [6:0]  MW_TOP_ADDR    = 7'h07;
    localparam logic [7:0]  RESET_VALUE    = 8'h00;
    localparam logic [7:0]  CARE_MASK      = 8'hff;
    typedef enum logic [2:0] {
        ST_HOLD  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_WAIT  = 3'b010,
        ST_STORE = 3'b011,
        ST_RUN   = 3'b100
    } boot_state_t;
    typedef enum logic [1:0] {
        SP_IDLE = 2'b00,
        SP_ADDR = 2'b01,
        SP_DATA = 2'b10
    } serial_state_t;
endpackage

// File: logic/host_register_access_boot.sv
`timescale 1ns/1ps
`default_nettype none
module host_register_access_boot #(
    parameter int unsigned HOLDOFF = host_access_pkg::HOLDOFF_CYCLES,
    parameter int unsigned ACCESS  = host_access_pkg::EPROM_CYCLES
) (
    input  wire logic                             sys_clk,
    input  wire logic                             reset,
    input  wire logic                             power_on_reset_n,
    input  wire logic                             boot_mode,
    input  wire logic                             serial_clk,
    input  wire logic                             chip_select_n,
    input  wire logic                             serial_host_in,
    input  wire logic                             output_edge_select,
    output logic                                  serial_host_out,
    output logic                                  serial_out_en_n,
    output logic [host_access_pkg::ADDR_W-1:0]    mem_addr,
    output logic                                  mem_select_n,
    output logic                                  mem_bus_master,
    input  wire logic [host_access_pkg::DATA_W-1:0] mem_data,
    output logic                                  in_reset,
    output logic [2*host_access_pkg::DATA_W-1:0]  mw_value
);
    localparam int unsigned AW = host_access_pkg::ADDR_W;
    localparam int unsigned DW = host_access_pkg::DATA_W;
    // Wait counter is only 16 bits wide
    if (HOLDOFF < 1 || ACCESS < 1 || ACCESS > 65536) begin : g_bad_counts
        $error("Counts out of range");
    end

    // Async assert, synchronous release of the power-on reset
    logic por_meta, por_sync;
    always_ff @(posedge sys_clk or negedge power_on_reset_n) begin
        if (!power_on_reset_n) begin
            por_meta <= 1'b0;
            por_sync <= 1'b0;
        end else begin
            por_meta <= 1'b1;
            por_sync <= por_meta;
        end
    end
    logic [31:0] hold_count;
    logic        hold_done;
    always_ff @(posedge sys_clk or negedge por_sync) begin
        if (!por_sync) begin
            hold_count <= 32'h0;
            hold_done  <= 1'b0;
        end else if (reset) begin
            hold_count <= 32'h0;
            hold_done  <= 1'b0;
        end else if (!hold_done) begin
            hold_count <= hold_count + 32'h1;
            hold_done  <= (hold_count == 32'(HOLDOFF - 1));
        end
    end
    logic rst;
    assign rst      = !por_sync || reset || !hold_done;
    assign in_reset = rst;

    // Serial pins cross into sys_clk by two flops each
    logic [1:0] sclk_s, cs_s, sdi_s, edge_s, boot_s;
    always_ff @(posedge sys_clk) begin
        sclk_s <= {sclk_s[0], serial_clk};
        cs_s   <= {cs_s[0], chip_select_n};
        sdi_s  <= {sdi_s[0], serial_host_in};
        edge_s <= {edge_s[0], output_edge_select};
        boot_s <= {boot_s[0], boot_mode};
    end
    logic sclk_d, boot_done;
    always_ff @(posedge sys_clk) sclk_d <= sclk_s[1];
    logic sclk_rise, sclk_fall, cs_active;
    assign cs_active = !cs_s[1] && boot_done;
    assign sclk_rise = cs_active && sclk_s[1] && !sclk_d;
    assign sclk_fall = cs_active && !sclk_s[1] && sclk_d;

    // Register file
    logic [DW-1:0] regs [host_access_pkg::REG_COUNT];
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;

    // Serial port: R/W bit, 7 address bits, 8 data bits, LSB first
    host_access_pkg::serial_state_t sp_state;
    logic [3:0]    bit_count;
    logic          sp_read;
    logic [AW-1:0] sp_addr;
    logic [DW-1:0] sp_shift;
    logic          sp_wr;
    logic          sp_rd_start;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sp_state    <= host_access_pkg::SP_IDLE;
            bit_count   <= 4'h0;
            sp_read     <= 1'b0;
            sp_addr     <= '0;
            sp_shift    <= '0;
            sp_wr       <= 1'b0;
            sp_rd_start <= 1'b0;
        end else begin
            sp_wr       <= 1'b0;
            sp_rd_start <= 1'b0;
            if (!cs_active) begin
                sp_state  <= host_access_pkg::SP_IDLE;
                bit_count <= 4'h0;
            end else if (sclk_rise) begin
                case (sp_state)
                    host_access_pkg::SP_IDLE: begin
                        sp_read   <= sdi_s[1];
                        sp_state  <= host_access_pkg::SP_ADDR;
                        bit_count <= 4'h0;
                    end
                    host_access_pkg::SP_ADDR: begin
                        sp_addr   <= {sdi_s[1], sp_addr[AW-1:1]};
                        bit_count <= bit_count + 4'h1;
                        if (bit_count == 4'(AW - 1)) begin
                            sp_state    <= host_access_pkg::SP_DATA;
                            bit_count   <= 4'h0;
                            sp_rd_start <= sp_read;
                        end
                    end
                    host_access_pkg::SP_DATA: begin
                        sp_shift  <= {sdi_s[1], sp_shift[DW-1:1]};
                        bit_count <= bit_count + 4'h1;
                        if (bit_count == 4'(DW - 1)) begin
                            sp_wr    <= !sp_read;
                            sp_state <= host_access_pkg::SP_IDLE;
                        end
                    end
                    default: sp_state <= host_access_pkg::SP_IDLE;
                endcase
            end
        end
    end

    // Multi-word: low word staged, applied on high word write
    logic [DW-1:0] mw_stage;
    logic          mw_pending;
    logic [DW-1:0] frozen_word;
    logic          access_evt;
    assign access_evt = sp_wr || sp_rd_start;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mw_stage   <= host_access_pkg::RESET_VALUE;
            mw_pending <= 1'b0;
            mw_value   <= '0;
        end else if (access_evt || wr_en) begin
            // Boot stores go through here too, so the loaded pair takes effect
            mw_pending <= 1'b0;
            if (wr_en && wr_addr == host_access_pkg::MW_LOW_ADDR) begin
                mw_stage   <= wr_data;
                mw_pending <= 1'b1;
            end else if (wr_en && wr_addr == host_access_pkg::MW_HIGH_ADDR && mw_pending) begin
                mw_value <= {wr_data, mw_stage};
            end
        end
    end

    // Boot sequencer
    host_access_pkg::boot_state_t bt_state;
    logic [15:0] acc_count;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bt_state       <= host_access_pkg::ST_HOLD;
            mem_addr       <= '0;
            mem_select_n   <= 1'b1;
            mem_bus_master <= 1'b0;
            acc_count      <= 16'h0;
            boot_done      <= 1'b0;
        end else begin
            case (bt_state)
                host_access_pkg::ST_HOLD: begin
                    if (boot_s[1]) begin
                        bt_state       <= host_access_pkg::ST_ADDR;
                        mem_bus_master <= 1'b1;
                    end else begin
                        bt_state  <= host_access_pkg::ST_RUN;
                        boot_done <= 1'b1;
                    end
                end
                host_access_pkg::ST_ADDR: begin
                    mem_select_n <= 1'b0;
                    acc_count    <= 16'h0;
                    bt_state     <= host_access_pkg::ST_WAIT;
                end
                host_access_pkg::ST_WAIT: begin
                    acc_count <= acc_count + 16'h1;
                    if (acc_count == 16'(ACCESS - 1)) begin
                        bt_state <= host_access_pkg::ST_STORE;
                    end
                end
                host_access_pkg::ST_STORE: begin
                    if (mem_addr == AW'(host_access_pkg::REG_COUNT - 1)) begin
                        bt_state       <= host_access_pkg::ST_RUN;
                        mem_select_n   <= 1'b1;
                        mem_bus_master <= 1'b0;
                        boot_done      <= 1'b1;
                    end else begin
                        mem_addr <= mem_addr + AW'(1);
                        bt_state <= host_access_pkg::ST_ADDR;
                    end
                end
                host_access_pkg::ST_RUN: bt_state <= host_access_pkg::ST_RUN;
                default:                 bt_state <= host_access_pkg::ST_HOLD;
            endcase
        end
    end

    always_comb begin
        wr_en   = 1'b0;
        wr_addr = sp_addr;
        wr_data = sp_shift & host_access_pkg::CARE_MASK;
        if (bt_state == host_access_pkg::ST_STORE) begin
            wr_en   = 1'b1;
            wr_addr = mem_addr;
            wr_data = mem_data & host_access_pkg::CARE_MASK;
        end else if (sp_wr && sp_addr < AW'(host_access_pkg::REG_COUNT)) begin
            wr_en = 1'b1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < host_access_pkg::REG_COUNT; i++) begin
                regs[i] <= host_access_pkg::RESET_VALUE;
            end
        end else if (wr_en) begin
            regs[wr_addr] <= wr_data;
        end
    end

    // Read data: low-word read freezes the high word
    logic [DW-1:0] rd_word;
    logic          frozen_valid;
    always_comb begin
        rd_word = '0;
        if (sp_addr < AW'(host_access_pkg::REG_COUNT)) begin
            rd_word = regs[sp_addr];
        end
        if (sp_addr == host_access_pkg::MW_LOW_ADDR) rd_word = mw_value[DW-1:0];
        if (sp_addr == host_access_pkg::MW_HIGH_ADDR) rd_word = mw_value[2*DW-1:DW];
        if (frozen_valid && sp_addr == host_access_pkg::MW_HIGH_ADDR) rd_word = frozen_word;
    end
    logic [DW-1:0] out_shift;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            frozen_word     <= '0;
            frozen_valid    <= 1'b0;
            out_shift       <= '0;
            serial_host_out <= 1'b0;
        end else begin
            if (sp_rd_start) begin
                out_shift <= rd_word;
                if (sp_addr == host_access_pkg::MW_LOW_ADDR) begin
                    frozen_word  <= mw_value[2*DW-1:DW];
                    frozen_valid <= 1'b1;
                end else if (sp_addr != host_access_pkg::MW_HIGH_ADDR) begin
                    frozen_valid <= 1'b0;
                end
            end else if (sp_state == host_access_pkg::SP_DATA && sp_read &&
                         (edge_s[1] ? sclk_fall : sclk_rise)) begin
                serial_host_out <= out_shift[0];
                out_shift       <= {1'b0, out_shift[DW-1:1]};
            end
        end
    end
    // Driver released whenever not in a read data phase
    assign serial_out_en_n = !(cs_active && sp_state == host_access_pkg::SP_DATA && sp_read);
endmodule
`default_nettype wire

// File: dv/host_access_props.sv
`timescale 1ns/1ps
`default_nettype none
module host_access_props #(
    parameter int unsigned HOLDOFF = 20,
    parameter int unsigned ACCESS  = 3
) (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        power_on_reset_n,
    input wire logic        serial_out_en_n,
    input wire logic [6:0]  mem_addr,
    input wire logic        mem_select_n,
    input wire logic        mem_bus_master,
    input wire logic        in_reset,
    input wire logic [15:0] mw_value
);
    localparam int REL_MAX = ACCESS + 8;
    int unsigned   held;
    // Counts hold-off cycles, so a short count shows at the fall
    always_ff @(posedge sys_clk) begin
        if (reset || !power_on_reset_n) begin
            held <= 0;
        end else if (in_reset) begin
            held <= held + 1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset || !power_on_reset_n);
    sequence boot_step;
        mem_bus_master && $changed(mem_addr);
    endsequence
    a_por_clear: assert property (disable iff (reset)
        !power_on_reset_n |=> in_reset && mw_value == 16'h0000) else $error("Not cleared");
    a_holdoff_span: assert property (
        $fell(in_reset) |-> held >= HOLDOFF && held <= HOLDOFF + 3) else $error("Bad hold-off");
    a_idle_in_reset: assert property (
        in_reset |-> serial_out_en_n && mem_select_n && !mem_bus_master) else $error("Busy in reset");
    a_boot_from_zero: assert property (
        $rose(mem_bus_master) |-> mem_addr == 7'h00) else $error("Boot start address");
    a_addr_steps: assert property (
        boot_step |-> $past(mem_bus_master) && mem_addr == $past(mem_addr) + 7'h01)
        else $error("Address skipped");
    a_slow_access: assert property (
        boot_step |=> $stable(mem_addr) [*2]) else $error("Access too short");
    a_boot_release: assert property (
        mem_bus_master && mem_addr == 7'h75 |-> ##[1:REL_MAX] !mem_bus_master && mem_select_n)
        else $error("Bus not released");
    a_select_owner: assert property (
        !mem_bus_master |-> mem_select_n) else $error("Select without bus");
    a_quiet_in_boot: assert property (
        mem_bus_master |-> serial_out_en_n) else $error("Serial driven in boot");
endmodule
bind host_register_access_boot host_access_props #(
    .HOLDOFF (HOLDOFF),
    .ACCESS  (ACCESS)
) u_host_access_props (
    .sys_clk          (sys_clk),
    .reset            (reset),
    .power_on_reset_n (power_on_reset_n),
    .serial_out_en_n  (serial_out_en_n),
    .mem_addr         (mem_addr),
    .mem_select_n     (mem_select_n),
    .mem_bus_master   (mem_bus_master),
    .in_reset         (in_reset),
    .mw_value         (mw_value)
);
`default_nettype wire

// File: dv/eprom_model.sv
`timescale 1ns/1ps
`default_nettype none
module eprom_model (
    input  wire logic       sys_clk,
    input  wire logic [6:0] mem_addr,
    input  wire logic       mem_select_n,
    output logic      [7:0] mem_data
);
    // Deselected bus toggles, so a stale sample cannot pass
    assign mem_data = mem_select_n ? {8{sys_clk}} ^ 8'h5a : {1'b0, mem_addr} ^ 8'ha5;
endmodule
`default_nettype wire

// File: dv/host_register_access_boot_tb.sv
`timescale 1ns/1ps
`default_nettype none
module host_register_access_boot_tb;
    localparam int HOLD = 20;
    localparam int PH   = 5;
    logic        sys_clk            = 1'b0;
    logic        reset              = 1'b1;
    logic        power_on_reset_n   = 1'b0;
    logic        boot_mode          = 1'b0;
    logic        serial_clk         = 1'b0;
    logic        chip_select_n      = 1'b1;
    logic        serial_host_in     = 1'b0;
    logic        output_edge_select = 1'b0;
    logic        serial_host_out;
    logic        serial_out_en_n;
    logic [6:0]  mem_addr;
    logic        mem_select_n;
    logic        mem_bus_master;
    logic [7:0]  mem_data;
    logic        in_reset;
    logic [15:0] mw_value;
    int          fails     = 0;
    int          cmp_count = 0;
    int          cycles    = 0;
    int          n;
    logic [31:0] seed      = 32'h0000005b;
    logic [6:0]  addr;
    logic [7:0]  rd;
    logic        so;
    logic        oe;
    logic        drv;
    always #5 sys_clk = ~sys_clk;
    host_register_access_boot #(.HOLDOFF(HOLD), .ACCESS(3)) u_host_register_access_boot (
        .sys_clk(sys_clk), .reset(reset), .power_on_reset_n(power_on_reset_n),
        .boot_mode(boot_mode), .serial_clk(serial_clk), .chip_select_n(chip_select_n),
        .serial_host_in(serial_host_in), .output_edge_select(output_edge_select),
        .serial_host_out(serial_host_out), .serial_out_en_n(serial_out_en_n),
        .mem_addr(mem_addr), .mem_select_n(mem_select_n), .mem_bus_master(mem_bus_master),
        .mem_data(mem_data), .in_reset(in_reset), .mw_value(mw_value));
    eprom_model u_eprom_model (.sys_clk(sys_clk), .mem_addr(mem_addr),
        .mem_select_n(mem_select_n), .mem_data(mem_data));
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            $display("[ERR] %0t timeout", $time);
            give_verdict();
        end
    end
    task automatic compare(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Host sees settled outputs half a cycle before each phase ends
    task automatic phase();
        repeat (PH - 1) @(posedge sys_clk);
        @(negedge sys_clk);
        so = serial_host_out;
        oe = serial_out_en_n;
        @(posedge sys_clk);
    endtask
    task automatic restart(input logic boot);
        boot_mode <= boot;
        reset     <= 1'b1;
        repeat (5) @(posedge sys_clk);
        reset            <= 1'b0;
        power_on_reset_n <= 1'b1;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (in_reset === 1'b1 && n < 200);
        compare({15'h0000, n >= HOLD && n <= HOLD + 4}, 16'h0001, "hold-off");
        @(posedge sys_clk);
    endtask
    // Frame: direction bit, address, data, all sent low bit first
    task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] wd);
        logic [15:0] v;
        v = {wd, a, rw};
        chip_select_n <= 1'b0;
        phase();
        for (int k = 0; k < 16; k++) begin
            serial_host_in <= v[k];
            phase();
            if (k > 7 && output_edge_select) rd[k-8] = so;
            if (k == 12) drv = !oe;
            serial_clk <= 1'b1;
            phase();
            if (k > 7 && !output_edge_select) rd[k-8] = so;
            serial_clk <= 1'b0;
        end
        phase();
        chip_select_n  <= 1'b1;
        serial_host_in <= ~serial_host_in;
        phase();
    endtask
    initial begin
        restart(1'b0);
        compare(mw_value, 16'h0000, "default");
        for (int i = 0; i < 8; i++) begin
            seed = next_rand(seed);
            output_edge_select <= i[0];
            addr = seed[6:0] % 7'h68 + 7'h0e;
            xfer(1'b0, addr, seed[15:8]);
            compare({15'h0000, drv}, 16'h0000, "quiet write");
            xfer(1'b1, addr, seed[23:16]);
            compare({15'h0000, drv}, 16'h0001, "drive read");
            compare({8'h00, rd}, {8'h00, seed[15:8]}, "readback");
        end
        xfer(1'b0, 7'h7a, 8'h3c);
        xfer(1'b1, 7'h7a, 8'hff);
        compare({8'h00, rd}, 16'h0000, "unmapped");
        $display("Test single registers done");
        xfer(1'b0, 7'h0c, 8'h34);
        compare(mw_value, 16'h0000, "half pair");
        xfer(1'b0, 7'h0d, 8'h12);
        compare(mw_value, 16'h1234, "pair");
        xfer(1'b1, 7'h0c, 8'h00);
        compare({8'h00, rd}, 16'h0034, "low word read");
        xfer(1'b0, 7'h0c, 8'h78);
        xfer(1'b0, 7'h0d, 8'h56);
        compare(mw_value, 16'h5678, "second pair");
        xfer(1'b1, 7'h0d, 8'h00);
        compare({8'h00, rd}, 16'h0012, "frozen high word");
        xfer(1'b0, 7'h0c, 8'hcd);
        xfer(1'b1, 7'h05, 8'h00);
        xfer(1'b0, 7'h0d, 8'hab);
        compare(mw_value, 16'h5678, "broken pair");
        $display("Test multi-word done");
        @(negedge sys_clk);
        #2 power_on_reset_n = 1'b0;
        #5 power_on_reset_n = 1'b1;
        compare({in_reset, mw_value[14:0]}, 16'h8000, "short reset pulse");
        @(posedge sys_clk);
        restart(1'b1);
        // Host tries a read while the sequencer owns the memory bus
        xfer(1'b1, 7'h0b, 8'h00);
        compare({8'h00, rd}, 16'h0000, "silent in boot");
        compare({15'h0000, drv}, 16'h0000, "no drive in boot");
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while ((n < 3 || mem_bus_master === 1'b1) && n < 3000);
        compare({15'h0000, mem_bus_master}, 16'h0000, "boot end");
        @(posedge sys_clk);
        for (int i = 0; i < 4; i++) begin
            addr = (i == 3) ? 7'h75 : 7'h0b + i[6:0];
            xfer(1'b1, addr, 8'h00);
            compare({8'h00, rd}, {8'h00, {1'b0, addr} ^ 8'ha5}, "boot load");
        end
        $display("Test boot done");
        give_verdict();
    end
endmodule
`default_nettype wire
